// [include/dma_chan_evt_defs.vh]
// register offsets, field positions and reset values of the channel event block
`ifndef DMA_CHAN_EVT_DEFS_VH
`define DMA_CHAN_EVT_DEFS_VH
`define OFS_EVENT_CONTROL 12'h000
`define OFS_INTERRUPT_CONTROL 12'h004
`define OFS_SOURCE_START_ADDRESS 12'h008
`define OFS_CHANNEL_CONTROL 12'h00c
`define OFS_EVENT_INPUTS 12'h010
`define EVT_ABORT_NUM_HI 23
`define EVT_ABORT_NUM_LO 16
`define EVT_START_NUM_HI 15
`define EVT_START_NUM_LO 8
`define EVT_FORCE_BIT 7
`define EVT_ABORT_BIT 6
`define EVT_PATTERN_EN_BIT 5
`define EVT_START_EN_BIT 4
`define EVT_ABORT_EN_BIT 3
`define INT_IE_HI 23
`define INT_IE_LO 16
`define INT_IF_HI 7
`define INT_IF_LO 0
`define FLAG_SRC_DONE 7
`define FLAG_SRC_HALF 6
`define FLAG_DST_DONE 5
`define FLAG_DST_HALF 4
`define FLAG_BLOCK 3
`define FLAG_CELL 2
`define FLAG_ABORT 1
`define FLAG_ADDR_ERR 0
`define CHC_ENABLE_BIT 7
`define CHC_EVT_DIS_BIT 6
`define CHC_BUSY_BIT 15
`define RST_REQUEST_NUM 8'hff
`endif

// [core/dma_chan_evt.v]
// per-channel event and interrupt control of a dma channel, apb slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "dma_chan_evt_defs.vh"
module dma_chan_evt #(
  parameter PTR_W = 16
)(
  input wire I_CORE_CLK,
  input wire I_SRST,
  input wire I_CE,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output reg O_PREADY,
  output reg [31:0] O_PRDATA,
  output reg O_PSLVERR,
  input wire I_IRQ_VALID,
  input wire [7:0] I_IRQ_NUM,
  input wire [PTR_W-1:0] I_SOURCE_POINTER,
  input wire [PTR_W-1:0] I_SOURCE_SIZE,
  input wire [PTR_W-1:0] I_DEST_POINTER,
  input wire [PTR_W-1:0] I_DEST_SIZE,
  input wire I_CELL_DONE,
  input wire I_BLOCK_DONE,
  input wire I_PATTERN_MATCH,
  input wire I_ADDR_ERROR,
  input wire I_XFER_BUSY,
  output reg O_START,
  output reg O_ABORT,
  output reg O_CHANNEL_ENABLE,
  output reg [31:0] O_SOURCE_START_ADDRESS,
  output reg O_IRQ
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [7:0] abort_request_number_q;
  reg [7:0] start_request_number_q;
  reg pattern_abort_enable_q;
  reg start_request_enable_q;
  reg abort_request_enable_q;
  reg [7:0] ie_q;
  reg [7:0] flag_q;
  reg channel_enable_bit_q;
  reg events_when_disabled_q;
  reg [PTR_W-1:0] src_ptr_prev_q;
  reg [PTR_W-1:0] dst_ptr_prev_q;
  reg [7:0] flag_set;
  reg [31:0] rdata_d;
  reg hit;

  wire access_phase;
  wire wr_en;
  wire wr_evt;
  wire wr_int;
  wire wr_chc;
  wire events_ok;
  wire start_irq_hit;
  wire abort_irq_hit;
  wire pattern_abort;
  wire do_abort;
  wire do_start;
  wire src_moved;
  wire dst_moved;
  wire wr_ssa;
  wire channel_enable_bit_d;
  wire [7:0] flag_d;
  wire [7:0] ie_d;
  wire [7:0] irq_src;
  genvar fb;

  // slave answers after one wait state: access phase is the cycle before ready
  assign access_phase = I_PSEL & I_PENABLE & ~O_PREADY;
  assign wr_en = access_phase & I_PWRITE;
  assign wr_evt = wr_en & (I_PADDR == `OFS_EVENT_CONTROL);
  assign wr_int = wr_en & (I_PADDR == `OFS_INTERRUPT_CONTROL);
  assign wr_chc = wr_en & (I_PADDR == `OFS_CHANNEL_CONTROL);
  assign wr_ssa = wr_en & (I_PADDR == `OFS_SOURCE_START_ADDRESS);

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // disabled channel gating
  assign events_ok = channel_enable_bit_q | events_when_disabled_q;
  assign start_irq_hit = I_IRQ_VALID & start_request_enable_q & events_ok
    & (I_IRQ_NUM == start_request_number_q);
  assign abort_irq_hit = I_IRQ_VALID & abort_request_enable_q & events_ok
    & (I_IRQ_NUM == abort_request_number_q);
  assign pattern_abort = I_PATTERN_MATCH & pattern_abort_enable_q;
  assign do_abort = abort_irq_hit | pattern_abort
    | (wr_evt & I_PWDATA[`EVT_ABORT_BIT]);
  // requested or forced start strobe; abort in same cycle wins
  assign do_start = ~do_abort & (start_irq_hit | (wr_evt & I_PWDATA[`EVT_FORCE_BIT]));

  // pointer compare only on movement, so a parked pointer sets once
  assign src_moved = I_SOURCE_POINTER != src_ptr_prev_q;
  assign dst_moved = I_DEST_POINTER != dst_ptr_prev_q;

  // ----------------------------------------------------------------
  // flag set sources
  // ----------------------------------------------------------------
  always @*
  begin
    flag_set = 8'h00;
    flag_set[`FLAG_SRC_DONE] = src_moved & (I_SOURCE_POINTER == I_SOURCE_SIZE);
    flag_set[`FLAG_SRC_HALF] = src_moved
      & (I_SOURCE_POINTER == {1'b0, I_SOURCE_SIZE[PTR_W-1:1]});
    flag_set[`FLAG_DST_DONE] = dst_moved & (I_DEST_POINTER == I_DEST_SIZE);
    flag_set[`FLAG_DST_HALF] = dst_moved
      & (I_DEST_POINTER == {1'b0, I_DEST_SIZE[PTR_W-1:1]});
    flag_set[`FLAG_BLOCK] = I_BLOCK_DONE | I_PATTERN_MATCH;
    flag_set[`FLAG_CELL] = I_CELL_DONE;
    flag_set[`FLAG_ABORT] = abort_irq_hit;
    flag_set[`FLAG_ADDR_ERR] = I_ADDR_ERROR;
  end

  // ----------------------------------------------------------------
  // flag next state
  // ----------------------------------------------------------------
  // enables as they will stand after this edge
  assign ie_d = wr_int ? I_PWDATA[`INT_IE_HI:`INT_IE_LO] : ie_q;

  // every flag follows one recipe, so one loop builds all eight;
  // a hardware set beats a software clear in the same cycle, so an
  // event in the write cycle itself survives a software clear
  generate
    for (fb = 0; fb < 8; fb = fb + 1)
    begin : g_flag
      assign flag_d[fb] = flag_set[fb]
        | (wr_int ? I_PWDATA[`INT_IF_LO + fb] : flag_q[fb]);
      assign irq_src[fb] = flag_d[fb] & ie_d[fb];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_d = 32'h0000_0000;
    hit = 1'b1;
    case (I_PADDR)
      `OFS_EVENT_CONTROL:
      begin
        // strobes and unused bits read zero
        rdata_d[`EVT_ABORT_NUM_HI:`EVT_ABORT_NUM_LO] = abort_request_number_q;
        rdata_d[`EVT_START_NUM_HI:`EVT_START_NUM_LO] = start_request_number_q;
        rdata_d[`EVT_PATTERN_EN_BIT] = pattern_abort_enable_q;
        rdata_d[`EVT_START_EN_BIT] = start_request_enable_q;
        rdata_d[`EVT_ABORT_EN_BIT] = abort_request_enable_q;
      end
      `OFS_INTERRUPT_CONTROL:
      begin
        rdata_d[`INT_IE_HI:`INT_IE_LO] = ie_q;
        rdata_d[`INT_IF_HI:`INT_IF_LO] = flag_q;
      end
      `OFS_SOURCE_START_ADDRESS:
        rdata_d = O_SOURCE_START_ADDRESS;
      `OFS_CHANNEL_CONTROL:
      begin
        rdata_d[`CHC_BUSY_BIT] = I_XFER_BUSY;
        rdata_d[`CHC_ENABLE_BIT] = channel_enable_bit_q;
        rdata_d[`CHC_EVT_DIS_BIT] = events_when_disabled_q;
      end
      `OFS_EVENT_INPUTS:
      begin
        rdata_d[7:0] = I_IRQ_NUM;
        rdata_d[8] = I_IRQ_VALID;
      end
      default:
        hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // ready is a flop, so every access costs one wait state; in exchange
  // the address decode never sits in the path from the bus to ready
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else if (I_CE)
    begin
      O_PREADY <= access_phase;
      // unmapped offsets answer with an error instead of stalling
      O_PSLVERR <= access_phase & ~hit;
      if (access_phase & ~I_PWRITE)
      begin
        O_PRDATA <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // event control storage
  // ----------------------------------------------------------------
  // strobes are never stored, which is why they read back as zero
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      abort_request_number_q <= `RST_REQUEST_NUM;
      start_request_number_q <= `RST_REQUEST_NUM;
      pattern_abort_enable_q <= 1'b0;
      start_request_enable_q <= 1'b0;
      abort_request_enable_q <= 1'b0;
    end
    else if (I_CE & wr_evt)
    begin
      abort_request_number_q <= I_PWDATA[`EVT_ABORT_NUM_HI:`EVT_ABORT_NUM_LO];
      start_request_number_q <= I_PWDATA[`EVT_START_NUM_HI:`EVT_START_NUM_LO];
      pattern_abort_enable_q <= I_PWDATA[`EVT_PATTERN_EN_BIT];
      start_request_enable_q <= I_PWDATA[`EVT_START_EN_BIT];
      abort_request_enable_q <= I_PWDATA[`EVT_ABORT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupt control storage and request
  // ----------------------------------------------------------------
  // the request follows the next-state flags and enables, so it rises
  // on the same edge as the flag that causes it
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      ie_q <= 8'h00;
      flag_q <= 8'h00;
      O_IRQ <= 1'b0;
    end
    else if (I_CE)
    begin
      ie_q <= ie_d;
      flag_q <= flag_d;
      O_IRQ <= |irq_src;
    end
  end

  // ----------------------------------------------------------------
  // source start address
  // ----------------------------------------------------------------
  // no translation happens here: a virtual address written by
  // software would reach the engine unchanged
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      O_SOURCE_START_ADDRESS <= 32'h0000_0000;
    end
    else if (I_CE & wr_ssa)
    begin
      O_SOURCE_START_ADDRESS <= I_PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // channel control
  // ----------------------------------------------------------------
  // pattern abort beats a write of the enable
  assign channel_enable_bit_d = pattern_abort ? 1'b0
    : (wr_chc ? I_PWDATA[`CHC_ENABLE_BIT] : channel_enable_bit_q);

  // bit and output copy load the same next value, so the engine sees
  // a pattern abort on the same edge as software does
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      channel_enable_bit_q <= 1'b0;
      events_when_disabled_q <= 1'b0;
      O_CHANNEL_ENABLE <= 1'b0;
    end
    else if (I_CE)
    begin
      if (wr_chc)
      begin
        events_when_disabled_q <= I_PWDATA[`CHC_EVT_DIS_BIT];
      end
      channel_enable_bit_q <= channel_enable_bit_d;
      O_CHANNEL_ENABLE <= channel_enable_bit_d;
    end
  end

  // ----------------------------------------------------------------
  // engine strobes
  // ----------------------------------------------------------------
  // pulses as long as their cause, one cycle for a register write; the engine must act on them in that cycle
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      O_START <= 1'b0;
      O_ABORT <= 1'b0;
    end
    else if (I_CE)
    begin
      // start pulse, lost to an abort
      O_START <= do_start;
      O_ABORT <= do_abort;
    end
  end

  // ----------------------------------------------------------------
  // pointer history
  // ----------------------------------------------------------------
  // last pointer values, so a pointer parked on its limit sets once
  always @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      src_ptr_prev_q <= {PTR_W{1'b0}};
      dst_ptr_prev_q <= {PTR_W{1'b0}};
    end
    else if (I_CE)
    begin
      src_ptr_prev_q <= I_SOURCE_POINTER;
      dst_ptr_prev_q <= I_DEST_POINTER;
    end
  end

endmodule // dma_chan_evt

// [tb/dma_chan_evt_sva.sv]
// port assertions of the channel event block
`timescale 1ns/10ps
module dma_chan_evt_sva (
  input wire I_CORE_CLK,
  input wire I_SRST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire O_PREADY,
  input wire O_START,
  input wire O_ABORT,
  input wire [31:0] O_SOURCE_START_ADDRESS,
  input wire O_IRQ
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  // taken access edges; the bench drops clock enable only while the bus idles
  wire tk = I_PSEL && I_PENABLE && !O_PREADY;
  wire we = tk && I_PWRITE && I_PADDR == 12'h000;
  wire wi = tk && I_PWRITE && I_PADDR == 12'h004;
  wire wa = tk && I_PWRITE && I_PADDR == 12'h008;
  chk_ready_next: assert property (tk |=> O_PREADY)
    else $error("no ready");
  chk_ready_once: assert property (O_PREADY |=> !O_PREADY)
    else $error("long ready");
  chk_force_start: assert property (we && I_PWDATA[7] && !I_PWDATA[6] |=> O_START)
    else $error("no start");
  chk_abort_strobe: assert property (we && I_PWDATA[6] |=> O_ABORT)
    else $error("no abort");
  chk_abort_wins: assert property (O_ABORT |-> !O_START)
    else $error("start with abort");
  // a short reset also clears state, so it counts as a cause
  chk_irq_sticky: assert property ($fell(O_IRQ) |-> $past(wi || I_SRST))
    else $error("irq fell");
  chk_ssa_load: assert property (wa |=> O_SOURCE_START_ADDRESS == $past(I_PWDATA))
    else $error("address not loaded");
  chk_ssa_hold: assert property ($changed(O_SOURCE_START_ADDRESS) |-> $past(wa || I_SRST))
    else $error("address changed");
  cover property (O_START);
  cover property (O_ABORT);
  cover property ($fell(O_IRQ));
endmodule // dma_chan_evt_sva

// [tb/dma_evt_engine.sv]
// model of the interrupt sources and the transfer engine
`timescale 1ns/10ps
module dma_evt_engine (
  input wire logic clk,
  output logic iv,
  output logic [7:0] num,
  output logic [15:0] sp,
  output logic [15:0] ss,
  output logic [15:0] dp,
  output logic [15:0] ds,
  output logic [3:0] ev
);
  // fixed sizes, halves at 4 and 3
  assign ss = 16'h0008;
  assign ds = 16'h0006;
  initial {iv, num, sp, dp, ev} = {1'h0, 8'h5a, 32'h0, 4'h0};
  // one active cycle; a released number shows its inverse, never a stale match
  task automatic step(input logic v, input logic [7:0] n, input logic [3:0] e,
    input logic [15:0] s, input logic [15:0] d);
    @(posedge clk);
    {iv, num, ev, sp, dp} <= {v, n, e, s, d};
    @(posedge clk);
    {iv, num, ev} <= {1'h0, ~n, 4'h0};
  endtask
endmodule // dma_evt_engine

// [tb/dma_chan_evt_bench.sv]
// self-checking bench of the channel event block
`timescale 1ns/10ps
module dma_chan_evt_bench;
  logic clk = 1'h0, srst = 1'h1, sel = 1'h0, en = 1'h0, wr = 1'h0, ce = 1'h1;
  logic [11:0] adr = 12'h0;
  logic [31:0] wd = 32'h0, rdat, ssa, q;
  logic rdy, err, st, ab, ena, irq, iv;
  logic [7:0] num;
  logic [15:0] sp, ss, dp, ds;
  logic [3:0] ev;
  int n_fail = 0, checks = 0;
  // 25 MHz core clock
  always #20 clk = ~clk;
  dma_evt_engine eng (.clk, .iv, .num, .sp, .ss, .dp, .ds, .ev);
  dma_chan_evt #(.PTR_W(16)) DUT (.I_CORE_CLK(clk), .I_SRST(srst), .I_CE(ce), .I_PSEL(sel),
    .I_PENABLE(en), .I_PWRITE(wr), .I_PADDR(adr), .I_PWDATA(wd), .O_PREADY(rdy),
    .O_PRDATA(rdat), .O_PSLVERR(err), .I_IRQ_VALID(iv), .I_IRQ_NUM(num),
    .I_SOURCE_POINTER(sp), .I_SOURCE_SIZE(ss), .I_DEST_POINTER(dp), .I_DEST_SIZE(ds),
    .I_CELL_DONE(ev[0]), .I_BLOCK_DONE(ev[1]), .I_ADDR_ERROR(ev[2]), .I_PATTERN_MATCH(ev[3]),
    .I_XFER_BUSY(1'h0), .O_START(st), .O_ABORT(ab), .O_CHANNEL_ENABLE(ena),
    .O_SOURCE_START_ADDRESS(ssa), .O_IRQ(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    n_fail += (g !== e);
    if (g !== e)
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  // apb transfer; the request stands until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {sel, wr, adr, wd} <= {1'h1, w, a, d};
    @(posedge clk);
    en <= 1'h1;
    // no limit here: only the watchdog ends a wait
    do @(posedge clk); while (rdy !== 1'h1);
    q = rdat;
    chk({31'h0, err}, {31'h0, a > 12'h010});
    {sel, en} <= 2'h0;
  endtask
  task automatic rr(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  // partner event, then start and abort in the answering cycle
  task automatic evt(input logic v, input logic [7:0] n, input logic [3:0] e,
    input logic [1:0] x);
    eng.step(v, n, e, sp, dp);
    @(negedge clk);
    chk({30'h0, st, ab}, {30'h0, x});
  endtask
  task automatic t_regs;
    rr(12'h000, 32'h00ffff00);
    apb(1'h1, 12'h000, 32'h00ffff80);
    rr(12'h000, 32'h00ffff00);
    apb(1'h1, 12'h000, 32'hffffffff);
    rr(12'h000, 32'h00ffff38);
    apb(1'h1, 12'h004, 32'hffffffff);
    rr(12'h004, 32'h00ff00ff);
    apb(1'h1, 12'h008, 32'h8c3a51e7);
    chk(ssa, 32'h8c3a51e7);
    rr(12'h008, 32'h8c3a51e7);
    rr(12'h040, 32'h00000000);
  endtask
  task automatic t_events;
    apb(1'h1, 12'h004, 32'h00020000);
    apb(1'h1, 12'h00c, 32'h00000080);
    chk({31'h0, ena}, 32'h1);
    apb(1'h1, 12'h000, 32'h00211218);
    evt(1'h1, 8'h12, 4'h0, 2'h2);
    evt(1'h1, 8'h13, 4'h0, 2'h0);
    evt(1'h1, 8'h21, 4'h0, 2'h1);
    rr(12'h004, 32'h00020002);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h00c, 32'h00000000);
    evt(1'h1, 8'h21, 4'h0, 2'h0);
    apb(1'h1, 12'h00c, 32'h00000040);
    evt(1'h1, 8'h12, 4'h0, 2'h2);
    // a frozen block ignores a matching start
    @(posedge clk) ce <= 1'h0;
    evt(1'h1, 8'h12, 4'h0, 2'h0);
    @(posedge clk) ce <= 1'h1;
    apb(1'h1, 12'h000, 32'h00211200);
    evt(1'h1, 8'h12, 4'h0, 2'h0);
    evt(1'h1, 8'h21, 4'h0, 2'h0);
  endtask
  task automatic t_flags;
    apb(1'h1, 12'h004, 32'h00ff0000);
    chk({31'h0, irq}, 32'h0);
    eng.step(1'h0, 8'h00, 4'h0, 16'h0004, 16'h0003);
    rr(12'h004, 32'h00ff0050);
    eng.step(1'h0, 8'h00, 4'h0, 16'h0008, 16'h0006);
    rr(12'h004, 32'h00ff00f0);
    evt(1'h0, 8'h00, 4'h7, 2'h0);
    rr(12'h004, 32'h00ff00fd);
    apb(1'h1, 12'h000, 32'h00211238);
    apb(1'h1, 12'h00c, 32'h00000080);
    evt(1'h0, 8'h00, 4'h8, 2'h1);
    chk({31'h0, ena}, 32'h0);
    rr(12'h00c, 32'h00000000);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    t_regs();
    t_events();
    t_flags();
    finish_test();
  end
  // watchdog, far past the under two hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
endmodule // dma_chan_evt_bench
bind dma_chan_evt dma_chan_evt_sva chk_i (.I_CORE_CLK, .I_SRST, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .I_PWDATA, .O_PREADY, .O_START, .O_ABORT, .O_SOURCE_START_ADDRESS, .O_IRQ);
